// file: hdl/olag_pkg.sv
// Package: word map, field masks, life cycle states and request carrier
package olag_pkg;

	// ==========================================
	// Geometry
	localparam int OLAG_WORDS     = 512;
	localparam int OLAG_AW        = 9;
	localparam int OLAG_DW        = 32;

	// ==========================================
	// Word map
	localparam logic [8:0] OLAG_ROOT_KEY_LO   = 9'h000;
	localparam logic [8:0] OLAG_ROOT_KEY_HI   = 9'h007;
	localparam logic [8:0] OLAG_CM_PROV_KEY   = 9'h00B;
	localparam logic [8:0] OLAG_CM_IMG_KEY_LO = 9'h00C;
	localparam logic [8:0] OLAG_CM_IMG_KEY_HI = 9'h00F;
	localparam logic [8:0] OLAG_CM_FLAGS      = 9'h010;
	localparam logic [8:0] OLAG_HASH_LO       = 9'h011;
	localparam logic [8:0] OLAG_HASH_HI       = 9'h018;
	localparam logic [8:0] OLAG_DM_PROV_LO    = 9'h019;
	localparam logic [8:0] OLAG_DM_PROV_HI    = 9'h01C;
	localparam logic [8:0] OLAG_DM_IMG_LO     = 9'h01D;
	localparam logic [8:0] OLAG_DM_IMG_HI     = 9'h020;
	localparam logic [8:0] OLAG_DM_FLAGS      = 9'h021;
	localparam logic [8:0] OLAG_GP_FLAGS      = 9'h027;
	localparam logic [8:0] OLAG_DBG_LOCK_LO   = 9'h028;
	localparam logic [8:0] OLAG_DBG_LOCK_HI   = 9'h02B;
	localparam logic [8:0] OLAG_USER_LO       = 9'h040;
	localparam logic [8:0] OLAG_USER_HI       = 9'h1FE;

	// ==========================================
	// Field masks
	localparam logic [31:0] OLAG_FULL         = 32'hFFFF_FFFF;
	localparam logic [31:0] OLAG_NONE         = 32'h0000_0000;
	localparam logic [31:0] OLAG_CM_RD_ANY    = 32'hFF80_8000;
	localparam logic [31:0] OLAG_DM_RD_ANY    = 32'hFF80_80FF;
	localparam logic [31:0] OLAG_DM_WR_DM     = 32'h00FF_FFFF;
	localparam logic [31:0] OLAG_DM_WR_RSVD   = 32'h3F00_0000;
	localparam logic [31:0] OLAG_DM_WR_DM_RET = 32'h4000_0000;
	localparam logic [31:0] OLAG_DM_WR_CM_RET = 32'h8000_0000;
	localparam int          OLAG_HASH_CNT_LSB = 0;
	localparam int          OLAG_DM_RET_BIT   = 30;
	localparam int          OLAG_CM_RET_BIT   = 31;
	localparam int          OLAG_ROOT_CNT_LSB = 0;
	localparam int          OLAG_ROOT_CNT_W   = 8;

	// ==========================================
	// Reset values
	localparam logic [8:0]  OLAG_SCAN_RST     = 9'h000;
	localparam logic [8:0]  OLAG_ZCNT_RST     = 9'h000;
	localparam logic [31:0] OLAG_DATA_RST     = 32'h0000_0000;

	typedef enum logic [1:0] {
		OLAG_LCS_CHIP_MAKER,
		OLAG_LCS_DEVICE_MAKER,
		OLAG_LCS_SECURE,
		OLAG_LCS_RETURN
	} olag_lcs_t;

	typedef enum logic [1:0] {
		OLAG_ST_LOAD,
		OLAG_ST_SCAN,
		OLAG_ST_RUN
	} olag_state_t;

	typedef struct packed {
		logic        write;
		logic        engine;
		logic [8:0]  addr;
		logic [31:0] wdata;
	} olag_req_t;

endpackage

// file: hdl/olag_lcs_decode.sv
// Life cycle state decode from the two programmed-flag words
`timescale 1ns/100ps
`default_nettype none

module olag_lcs_decode
	import olag_pkg::*;
(
	input  wire logic [31:0] cm_flags_in,
	input  wire logic [31:0] dm_flags_in,
	output var  olag_lcs_t   lcs_out
);

	// ==========================================
	// Decode, return flags take priority
	always_comb
	begin
		if (dm_flags_in[OLAG_DM_RET_BIT] || dm_flags_in[OLAG_CM_RET_BIT])
			lcs_out = OLAG_LCS_RETURN;
		else if (cm_flags_in == OLAG_NONE)
			lcs_out = OLAG_LCS_CHIP_MAKER;
		else if (dm_flags_in[7:0] == 8'h00)
			lcs_out = OLAG_LCS_DEVICE_MAKER;
		else
			lcs_out = OLAG_LCS_SECURE;
	end

endmodule

`default_nettype wire

// file: hdl/olag_gate.sv
// One-time-programmable store with life cycle access gating
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - 2 kB store of 32-bit words
// - Words 0x00-0x2B closed to CPU
// - Root and chip-maker keys: CM read, CM/return write
// - Root hashes: read always, CM/DM write
// - DM provisioning key: CM/DM read, DM/return write
// - DM image key: CM/DM read, DM/return write
// - Config flags writable only in CM
// - Debug lock mask: read always, CM/DM write
// - User area readable in every state
// - CM flags [7:0] readable only in CM
// - CM flags [14:8] readable only in CM
// - CM flags bit 15 readable always
// - CM flags [22:16] CM-only, bit 23 always
// - CM flags [31:24] readable always
// - CM flags writable in CM or return
// - DM flags [7:0] readable always
// - DM flags [14:8] CM/DM, bit 15 always
// - DM flags [22:16] CM/DM, bit 23 always
// - DM flags [23:0] writable in DM/return
// - DM flags bit 30 writable CM/DM/secure
// - DM flags bit 31 also needs lock clear
// - CM flag word zero means CM state
// - Secure when DM hash count nonzero
module olag_gate
	import olag_pkg::*;
(
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RESETN_IN,
	input  wire logic        REQ_VALID_IN,
	input  wire olag_req_t   REQ_IN,
	input  wire logic        CM_RETURN_LOCK_IN,
	output var  logic        REQ_READY_OUT,
	output var  logic        RSP_VALID_OUT,
	output var  logic [31:0] RSP_RDATA_OUT,
	output var  logic        RSP_DENIED_OUT,
	output var  olag_lcs_t   LIFE_CYCLE_STATE_OUT,
	output var  logic        ROOT_KEY_COUNT_OK_OUT
);

	// ==========================================
	// Helpers
	function automatic logic in_range(
		input logic [8:0] a,
		input logic [8:0] lo,
		input logic [8:0] hi
	);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic key_area(input logic [8:0] a);
		key_area = in_range(a, OLAG_ROOT_KEY_LO, OLAG_ROOT_KEY_HI)
			|| (a == OLAG_CM_PROV_KEY)
			|| in_range(a, OLAG_CM_IMG_KEY_LO, OLAG_CM_IMG_KEY_HI);
	endfunction

	// CPU may not touch the engine-only words
	function automatic logic cpu_closed(
		input logic [8:0] a,
		input logic       engine
	);
		cpu_closed = !engine && (a <= OLAG_DBG_LOCK_HI);
	endfunction

	function automatic logic [5:0] zero_count(input logic [31:0] w);
		logic [5:0] n;
		n = 6'd0;
		for (int i = 0; i < OLAG_DW; i++)
			n = n + {5'd0, ~w[i]};
		zero_count = n;
	endfunction

	function automatic logic [31:0] read_mask(
		input logic [8:0] a,
		input olag_lcs_t  s,
		input logic       engine
	);
		logic cm;
		logic cmdm;
		logic [31:0] m;
		cm   = (s == OLAG_LCS_CHIP_MAKER);
		cmdm = cm || (s == OLAG_LCS_DEVICE_MAKER);
		m    = OLAG_NONE;
		if (key_area(a))
		begin
			m = cm ? OLAG_FULL : OLAG_NONE;
		end
		else if (a == OLAG_CM_FLAGS)
		begin
			m = cm ? OLAG_FULL : OLAG_CM_RD_ANY;
		end
		else if (in_range(a, OLAG_HASH_LO, OLAG_HASH_HI))
		begin
			m = OLAG_FULL;
		end
		else if (in_range(a, OLAG_DM_PROV_LO, OLAG_DM_PROV_HI))
		begin
			m = cmdm ? OLAG_FULL : OLAG_NONE;
		end
		else if (in_range(a, OLAG_DM_IMG_LO, OLAG_DM_IMG_HI))
		begin
			m = cmdm ? OLAG_FULL : OLAG_NONE;
		end
		else if (a == OLAG_DM_FLAGS)
		begin
			m = cmdm ? OLAG_FULL : OLAG_DM_RD_ANY;
		end
		else if (a == OLAG_GP_FLAGS)
		begin
			m = OLAG_FULL;
		end
		else if (in_range(a, OLAG_DBG_LOCK_LO, OLAG_DBG_LOCK_HI))
		begin
			m = OLAG_FULL;
		end
		else if (in_range(a, OLAG_USER_LO, OLAG_USER_HI))
		begin
			m = OLAG_FULL;
		end
		if (cpu_closed(a, engine))
		begin
			m = OLAG_NONE;
		end
		read_mask = m;
	endfunction

	function automatic logic [31:0] write_mask(
		input logic [8:0] a,
		input olag_lcs_t  s,
		input logic       engine,
		input logic       lock
	);
		logic cm;
		logic dm;
		logic ret;
		logic sec;
		logic [31:0] m;
		cm  = (s == OLAG_LCS_CHIP_MAKER);
		dm  = (s == OLAG_LCS_DEVICE_MAKER);
		sec = (s == OLAG_LCS_SECURE);
		ret = (s == OLAG_LCS_RETURN);
		m   = OLAG_NONE;
		if (key_area(a))
		begin
			m = (cm || ret) ? OLAG_FULL : OLAG_NONE;
		end
		else if (a == OLAG_CM_FLAGS)
		begin
			m = (cm || ret) ? OLAG_FULL : OLAG_NONE;
		end
		else if (in_range(a, OLAG_HASH_LO, OLAG_HASH_HI))
		begin
			m = (cm || dm) ? OLAG_FULL : OLAG_NONE;
		end
		else if (in_range(a, OLAG_DM_PROV_LO, OLAG_DM_PROV_HI))
		begin
			m = (dm || ret) ? OLAG_FULL : OLAG_NONE;
		end
		else if (in_range(a, OLAG_DM_IMG_LO, OLAG_DM_IMG_HI))
		begin
			m = (dm || ret) ? OLAG_FULL : OLAG_NONE;
		end
		else if (a == OLAG_DM_FLAGS)
		begin
			m = OLAG_DM_WR_RSVD;
			if (dm || ret)
				m = m | OLAG_DM_WR_DM;
			if (cm || dm || sec)
				m = m | OLAG_DM_WR_DM_RET;
			if ((cm || dm || sec) && !lock)
				m = m | OLAG_DM_WR_CM_RET;
		end
		else if (a == OLAG_GP_FLAGS)
		begin
			m = cm ? OLAG_FULL : OLAG_NONE;
		end
		else if (in_range(a, OLAG_DBG_LOCK_LO, OLAG_DBG_LOCK_HI))
		begin
			m = (cm || dm) ? OLAG_FULL : OLAG_NONE;
		end
		else if (in_range(a, OLAG_USER_LO, OLAG_USER_HI))
		begin
			m = OLAG_FULL;
		end
		if (cpu_closed(a, engine))
		begin
			m = OLAG_NONE;
		end
		write_mask = m;
	endfunction

	// ==========================================
	// Storage
	logic [31:0] mem_r [OLAG_WORDS];
	logic [OLAG_WORDS-1:0] prog_r;

	olag_state_t state_r;
	olag_lcs_t   lcs_r;
	olag_lcs_t   lcs_dec;
	logic [8:0]  scan_idx_r;
	logic [8:0]  zcnt_r;
	logic        count_ok_r;
	logic        ready_r;
	logic        rsp_valid_r;
	logic [31:0] rsp_rdata_r;
	logic        rsp_denied_r;

	logic [31:0] cm_flags;
	logic [31:0] dm_flags;
	logic [31:0] cur_word;
	logic [31:0] scan_word;
	logic [31:0] rmask;
	logic [31:0] wmask;
	logic        take;

	always_comb
	begin
		cm_flags  = prog_r[OLAG_CM_FLAGS] ? mem_r[OLAG_CM_FLAGS] : OLAG_NONE;
		dm_flags  = prog_r[OLAG_DM_FLAGS] ? mem_r[OLAG_DM_FLAGS] : OLAG_NONE;
		cur_word  = prog_r[REQ_IN.addr] ? mem_r[REQ_IN.addr] : OLAG_NONE;
		scan_word = prog_r[scan_idx_r] ? mem_r[scan_idx_r] : OLAG_NONE;
		rmask     = read_mask(REQ_IN.addr, lcs_r, REQ_IN.engine);
		wmask     = write_mask(REQ_IN.addr, lcs_r, REQ_IN.engine, CM_RETURN_LOCK_IN);
		take      = REQ_VALID_IN && ready_r;
	end

	olag_lcs_decode u_lcs_decode (
		.cm_flags_in (cm_flags),
		.dm_flags_in (dm_flags),
		.lcs_out     (lcs_dec)
	);

	// ==========================================
	// Start-up sequence: latch state, check root key count
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RESETN_IN)
		begin
			state_r    <= OLAG_ST_LOAD;
			lcs_r      <= OLAG_LCS_CHIP_MAKER;
			scan_idx_r <= OLAG_SCAN_RST;
			zcnt_r     <= OLAG_ZCNT_RST;
			count_ok_r <= 1'b0;
			ready_r    <= 1'b0;
		end
		else
		begin
			case (state_r)
				OLAG_ST_LOAD:
				begin
					lcs_r      <= lcs_dec;
					scan_idx_r <= OLAG_ROOT_KEY_LO;
					zcnt_r     <= OLAG_ZCNT_RST;
					state_r    <= OLAG_ST_SCAN;
				end
				OLAG_ST_SCAN:
				begin
					zcnt_r     <= zcnt_r + {3'd0, zero_count(scan_word)};
					scan_idx_r <= scan_idx_r + 9'd1;
					if (scan_idx_r == OLAG_ROOT_KEY_HI)
						state_r <= OLAG_ST_RUN;
				end
				OLAG_ST_RUN:
				begin
					ready_r    <= 1'b1;
					count_ok_r <= (zcnt_r[OLAG_ROOT_CNT_W-1:0]
						== cm_flags[OLAG_ROOT_CNT_LSB +: OLAG_ROOT_CNT_W]);
				end
				default:
					state_r <= OLAG_ST_LOAD;
			endcase
		end
	end

	// ==========================================
	// Burn: only permitted bits go to one
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (take && REQ_IN.write && (wmask != OLAG_NONE))
			mem_r[REQ_IN.addr] <= cur_word | (REQ_IN.wdata & wmask);
	end

	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RESETN_IN)
			prog_r <= '0;
		else if (take && REQ_IN.write && (wmask != OLAG_NONE))
			prog_r[REQ_IN.addr] <= 1'b1;
	end

	// ==========================================
	// Response
	always_ff @(posedge CLK_SYS_IN)
	begin
		if (!RESETN_IN)
		begin
			rsp_valid_r  <= 1'b0;
			rsp_rdata_r  <= OLAG_DATA_RST;
			rsp_denied_r <= 1'b0;
		end
		else
		begin
			rsp_valid_r <= take;
			if (take)
			begin
				if (REQ_IN.write)
				begin
					rsp_rdata_r  <= OLAG_DATA_RST;
					rsp_denied_r <= (wmask == OLAG_NONE)
						|| ((REQ_IN.wdata & ~wmask) != OLAG_NONE);
				end
				else
				begin
					rsp_rdata_r  <= cur_word & rmask;
					rsp_denied_r <= (rmask == OLAG_NONE);
				end
			end
		end
	end

	always_comb
	begin
		REQ_READY_OUT         = ready_r;
		RSP_VALID_OUT         = rsp_valid_r;
		RSP_RDATA_OUT         = rsp_rdata_r;
		RSP_DENIED_OUT        = rsp_denied_r;
		LIFE_CYCLE_STATE_OUT  = lcs_r;
		ROOT_KEY_COUNT_OK_OUT = count_ok_r;
	end

endmodule

`default_nettype wire

// file: bench/olag_engine_model.sv
// Security engine model issuing requests to the gate
`timescale 1ns/100ps
`default_nettype none

module olag_engine_model
	import olag_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        ready_in,
	input  wire logic        rsp_valid_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic        denied_in,
	output var  logic        valid_out,
	output var  olag_req_t   req_out
);
	initial
	begin
		valid_out = 1'b0;
		req_out = '0;
	end

	// ========
	// One transfer, held until taken
	task automatic xfer(input olag_req_t r, output logic [31:0] rd, output logic dn,
		output bit to);
		int n;
		to = 1'b1;
		@(posedge clk_in);
		#1;
		valid_out = 1'b1;
		req_out = r;
		for (n = 0; n < 20 && to; n++)
		begin
			@(posedge clk_in);
			if (ready_in === 1'b1)
				to = 1'b0;
		end
		#1;
		valid_out = 1'b0;
		// Released lines show garbage
		req_out = ~r;
		rd = rdata_in;
		dn = denied_in;
		if (rsp_valid_in !== 1'b1)
			to = 1'b1;
	endtask
endmodule

`default_nettype wire

// file: bench/olag_gate_properties.sv
// Port checks for the access gate
`timescale 1ns/100ps
`default_nettype none

module olag_gate_chk
	import olag_pkg::*;
(
	input wire logic        CLK_SYS_IN,
	input wire logic        RESETN_IN,
	input wire logic        REQ_VALID_IN,
	input wire olag_req_t   REQ_IN,
	input wire logic        CM_RETURN_LOCK_IN,
	input wire logic        REQ_READY_OUT,
	input wire logic        RSP_VALID_OUT,
	input wire logic [31:0] RSP_RDATA_OUT,
	input wire logic        RSP_DENIED_OUT,
	input wire olag_lcs_t   LIFE_CYCLE_STATE_OUT,
	input wire logic        ROOT_KEY_COUNT_OK_OUT
);
	// ========
	// Taken requests
	wire logic take = REQ_VALID_IN && REQ_READY_OUT;
	wire logic eng_rd = take && REQ_IN.engine && !REQ_IN.write;
	wire logic eng_wr = take && REQ_IN.engine && REQ_IN.write;
	wire logic cm = LIFE_CYCLE_STATE_OUT == OLAG_LCS_CHIP_MAKER;

	default clocking dc @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RESETN_IN);

	a_cpu_key_block: assert property (take && !REQ_IN.engine && REQ_IN.addr <= 9'h02B
		|=> RSP_DENIED_OUT && RSP_RDATA_OUT == 32'h0000_0000) else $error("cpu key access");
	a_user_read_open: assert property (take && !REQ_IN.write
		&& REQ_IN.addr inside {[9'h040:9'h1FE]} |=> RSP_VALID_OUT && !RSP_DENIED_OUT)
		else $error("user read denied");
	a_hash_read_open: assert property (eng_rd && REQ_IN.addr inside {[9'h011:9'h018]}
		|=> RSP_VALID_OUT && !RSP_DENIED_OUT) else $error("hash read denied");
	a_dbg_read_open: assert property (eng_rd && REQ_IN.addr inside {[9'h028:9'h02B]}
		|=> !RSP_DENIED_OUT) else $error("lock mask read denied");
	a_cm_key_read: assert property (eng_rd && cm
		&& REQ_IN.addr inside {[9'h000:9'h007], [9'h00B:9'h00F]} |=> !RSP_DENIED_OUT)
		else $error("key read denied");
	a_write_data_zero: assert property (take && REQ_IN.write
		|=> RSP_VALID_OUT && RSP_RDATA_OUT == 32'h0000_0000) else $error("write data");
	a_dm_key_block: assert property (eng_wr && cm && REQ_IN.addr inside {[9'h019:9'h020]}
		&& REQ_IN.wdata != 32'h0000_0000 |=> RSP_DENIED_OUT) else $error("dm key written");
	a_cm_flag_write: assert property (eng_wr && cm && REQ_IN.addr == 9'h010
		|=> !RSP_DENIED_OUT) else $error("cm flags refused");
	a_cm_default: assert property (REQ_READY_OUT |-> cm) else $error("state not cm");
endmodule

`default_nettype wire

// file: bench/tb.sv
// Testbench for the access gate in chip-maker state
`timescale 1ns/100ps
`default_nettype none

module tb
	import olag_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic        valid;
	olag_req_t   req;
	logic        lock;
	logic        ready;
	logic        rsp_v;
	logic [31:0] rdata;
	logic        denied;
	olag_lcs_t   lcs;
	logic        cnt_ok;
	int          n_fail = 0;
	int          n_compared = 0;

	always #20 clk = ~clk;

	olag_gate dut (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .REQ_VALID_IN(valid),
		.REQ_IN(req), .CM_RETURN_LOCK_IN(lock), .REQ_READY_OUT(ready),
		.RSP_VALID_OUT(rsp_v), .RSP_RDATA_OUT(rdata), .RSP_DENIED_OUT(denied),
		.LIFE_CYCLE_STATE_OUT(lcs), .ROOT_KEY_COUNT_OK_OUT(cnt_ok));
	olag_engine_model eng (.clk_in(clk), .ready_in(ready), .rsp_valid_in(rsp_v),
		.rdata_in(rdata), .denied_in(denied), .valid_out(valid), .req_out(req));

	// ========
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic op(input logic w, input logic e, input logic [8:0] a,
		input logic [31:0] d, input logic edn, input logic [31:0] erd);
		logic [31:0] rd;
		logic        dn;
		bit          to;
		eng.xfer('{w, e, a, d}, rd, dn, to);
		if (to)
		begin
			n_fail++;
			print_verdict();
		end
		chk("denied", {31'h0, dn}, {31'h0, edn});
		chk("rdata", rd, erd);
	endtask

	task automatic wr_rd(input logic e, input logic [8:0] a, input logic [31:0] d,
		input logic wdn, input logic rdn, input logic [31:0] erd);
		op(1'b1, e, a, d, wdn, 32'h0000_0000);
		op(1'b0, e, a, 32'h0000_0000, rdn, erd);
	endtask

	// ========
	// Scenarios
	task automatic t_startup();
		int n;
		for (n = 0; n < 30 && ready !== 1'b1; n++)
			@(posedge clk);
		#1;
		if (ready !== 1'b1)
		begin
			n_fail++;
			print_verdict();
		end
		chk("state", {30'h0, lcs}, {30'h0, OLAG_LCS_CHIP_MAKER});
		chk("count_ok", {31'h0, cnt_ok}, 32'h0000_0001);
		$display("startup done");
	endtask

	task automatic t_cpu();
		op(1'b0, 1'b0, 9'h000, 32'h0000_0000, 1'b1, 32'h0000_0000);
		op(1'b1, 1'b0, 9'h02B, 32'h0000_0001, 1'b1, 32'h0000_0000);
		wr_rd(1'b0, 9'h040, 32'h0000_A5A5, 1'b0, 1'b0, 32'h0000_A5A5);
		wr_rd(1'b0, 9'h1FE, 32'h8000_0001, 1'b0, 1'b0, 32'h8000_0001);
		$display("cpu done");
	endtask

	task automatic t_keys();
		wr_rd(1'b1, 9'h000, 32'h1234_0000, 1'b0, 1'b0, 32'h1234_0000);
		wr_rd(1'b1, 9'h00B, 32'h0000_0F0F, 1'b0, 1'b0, 32'h0000_0F0F);
		wr_rd(1'b1, 9'h00F, 32'h00F0_0000, 1'b0, 1'b0, 32'h00F0_0000);
		wr_rd(1'b1, 9'h011, 32'h0000_0001, 1'b0, 1'b0, 32'h0000_0001);
		wr_rd(1'b1, 9'h018, 32'h8000_0000, 1'b0, 1'b0, 32'h8000_0000);
		wr_rd(1'b1, 9'h019, 32'h0000_0001, 1'b1, 1'b0, 32'h0000_0000);
		wr_rd(1'b1, 9'h020, 32'h0000_0100, 1'b1, 1'b0, 32'h0000_0000);
		wr_rd(1'b1, 9'h027, 32'h0000_00C3, 1'b0, 1'b0, 32'h0000_00C3);
		wr_rd(1'b1, 9'h02B, 32'h0101_0000, 1'b0, 1'b0, 32'h0101_0000);
		wr_rd(1'b1, 9'h000, 32'h0000_0056, 1'b0, 1'b0, 32'h1234_0056);
		$display("keys done");
	endtask

	task automatic t_flags();
		wr_rd(1'b1, 9'h010, 32'hFFFF_FFFF, 1'b0, 1'b0, 32'hFFFF_FFFF);
		wr_rd(1'b1, 9'h021, 32'h0000_00FF, 1'b1, 1'b0, 32'h0000_0000);
		wr_rd(1'b1, 9'h021, 32'h4000_0000, 1'b0, 1'b0, 32'h4000_0000);
		lock = 1'b1;
		wr_rd(1'b1, 9'h021, 32'h8000_0000, 1'b1, 1'b0, 32'h4000_0000);
		lock = 1'b0;
		wr_rd(1'b1, 9'h021, 32'h8000_0000, 1'b0, 1'b0, 32'hC000_0000);
		$display("flags done");
	endtask

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		lock = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_startup();
		t_cpu();
		t_keys();
		t_flags();
		print_verdict();
	end
endmodule

bind olag_gate olag_gate_chk chk (.CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN),
	.REQ_VALID_IN(REQ_VALID_IN), .REQ_IN(REQ_IN), .CM_RETURN_LOCK_IN(CM_RETURN_LOCK_IN),
	.REQ_READY_OUT(REQ_READY_OUT), .RSP_VALID_OUT(RSP_VALID_OUT),
	.RSP_RDATA_OUT(RSP_RDATA_OUT), .RSP_DENIED_OUT(RSP_DENIED_OUT),
	.LIFE_CYCLE_STATE_OUT(LIFE_CYCLE_STATE_OUT), .ROOT_KEY_COUNT_OK_OUT(ROOT_KEY_COUNT_OK_OUT));

`default_nettype wire
